// *** rtl/dlwp_host.v ***
/*
 Host-side controller that drives a double-latched 16-bit converter write port.
 Samples arrive on a valid/ready stream, pass a FIFO, and are written with
 input-latch and converter-latch strobes; a zeroing request pulses the clear pin.
 Assumes the pins connect directly to the converter; all pins are outputs.
*/
// Function
// - Samples are passed through unchanged as two's complement codes.
// - The strobe stays low at least 50 ns on each double-buffered load.
// - The strobe stays low at least 80 ns in single-buffered transparent writes.
// - Clear stays low at least 200 ns.
`default_nettype none
`include "dlwp_defs.vh"
module dlwp_host #(
   parameter WIDTH = 16,
   parameter DEPTH = 16,
   parameter AW = 4
) (
   // Clock, reset and enable.
   input wire clk,
   input wire rst_n,
   input wire ce,
   // Sample stream.
   input wire sample_valid,
   output wire sample_ready,
   input wire [WIDTH-1:0] sample_data,
   // Mode: 1 writes each sample through both latches transparently.
   input wire single_buffer,
   // Zeroing request, a one-cycle pulse; honoured when idle.
   input wire zero_req,
   output wire busy,
   // Converter pins.
   output reg [WIDTH-1:0] dac_data,
   output reg input_latch_enable_n,
   output reg dac_latch_enable_n,
   output reg write_n,
   output reg zero_output_n,
   // Expected converter latch code.
   output reg [WIDTH-1:0] dac_code
);
   // ----------------------------------------
   // Timing counts
   // ----------------------------------------
   // Counts are worked out at full integer width, then cut to the counter width on purpose.
   localparam integer SETUP_I = `DLWP_CYC(`DLWP_SETUP_NS) - `DLWP_CYC(`DLWP_WRITE_LOW_NS) + 1;
   localparam integer WLOW_I = `DLWP_CYC(`DLWP_WRITE_LOW_NS);
   localparam integer SLOW_I = `DLWP_CYC(`DLWP_SINGLE_LOW_NS);
   localparam integer ZLOW_I = `DLWP_CYC(`DLWP_ZEROING_LOW_NS);
   localparam integer HOLD_I = `DLWP_CYC(`DLWP_HOLD_NS);
   localparam [7:0] SETUP_CYC = SETUP_I[7:0];
   localparam [7:0] WLOW_CYC = WLOW_I[7:0];
   localparam [7:0] SLOW_CYC = SLOW_I[7:0];
   localparam [7:0] ZLOW_CYC = ZLOW_I[7:0];
   localparam [7:0] HOLD_CYC = HOLD_I[7:0];

   // ----------------------------------------
   // States
   // ----------------------------------------
   localparam [5:0] S_IDLE = 6'h01;
   localparam [5:0] S_SETUP = 6'h02;
   localparam [5:0] S_LOW = 6'h04;
   localparam [5:0] S_HOLD = 6'h08;
   localparam [5:0] S_ZERO = 6'h10;
   localparam [5:0] S_GAP = 6'h20;

   reg [5:0] state;
   reg [7:0] cnt;
   reg phase_dac;
   reg single_mode;
   reg [WIDTH-1:0] in_latch;
   wire fifo_valid;
   wire fifo_ready;
   wire [WIDTH-1:0] fifo_data;

   // The FIFO absorbs bursts; its ready reaches the source as back-pressure.
   dlwp_fifo #(
      .WIDTH(WIDTH),
      .DEPTH(DEPTH),
      .AW(AW)
   ) u_fifo (
      .clk(clk),
      .rst_n(rst_n),
      .ce(ce),
      .in_valid(sample_valid),
      .in_ready(sample_ready),
      .in_data(sample_data),
      .out_valid(fifo_valid),
      .out_ready(fifo_ready),
      .out_data(fifo_data)
   );

   // A sample is popped only when idle with no zeroing pending, as zeroing has priority.
   assign fifo_ready = (state == S_IDLE) && !zero_req;
   assign busy = (state != S_IDLE);

   // ----------------------------------------
   // Write sequencer
   // ----------------------------------------
   // Each sample: set up pins, strobe low, release strobe, hold, then (double-buffered only) the
   // converter-latch phase; the strobe rises before enables change.
   always @(posedge clk) begin
      if (!rst_n) begin
         state <= S_IDLE;
         cnt <= 8'h00;
         phase_dac <= 1'b0;
         single_mode <= 1'b0;
         in_latch <= `DLWP_BIPOLAR_MIDPOINT;
         dac_code <= `DLWP_BIPOLAR_MIDPOINT;
         dac_data <= `DLWP_BIPOLAR_MIDPOINT;
         input_latch_enable_n <= 1'b1;
         dac_latch_enable_n <= 1'b1;
         write_n <= 1'b1;
         zero_output_n <= 1'b1;
      end else if (ce) begin
         case (state)
            S_IDLE: begin
               input_latch_enable_n <= 1'b1;
               dac_latch_enable_n <= 1'b1;
               write_n <= 1'b1;
               if (zero_req) begin
                  zero_output_n <= 1'b0;
                  cnt <= ZLOW_CYC;
                  state <= S_ZERO;
               end else if (fifo_valid) begin
                  dac_data <= fifo_data;
                  single_mode <= single_buffer;
                  phase_dac <= 1'b0;
                  input_latch_enable_n <= 1'b0;
                  dac_latch_enable_n <= single_buffer ? 1'b0 : 1'b1;
                  cnt <= SETUP_CYC;
                  state <= S_SETUP;
               end
            end
            S_SETUP: begin
               if (cnt <= 8'h01) begin
                  write_n <= 1'b0;
                  cnt <= single_mode ? SLOW_CYC : WLOW_CYC;
                  state <= S_LOW;
               end else begin
                  cnt <= cnt - 8'h01;
               end
            end
            S_LOW: begin
               if (cnt <= 8'h01) begin
                  write_n <= 1'b1;
                  cnt <= HOLD_CYC;
                  state <= S_HOLD;
                  // Latch model: input latch loads, converter latch follows on its load.
                  if (!phase_dac) begin
                     in_latch <= dac_data;
                  end
                  if (phase_dac || single_mode) begin
                     dac_code <= phase_dac ? in_latch : dac_data;
                  end
               end else begin
                  cnt <= cnt - 8'h01;
               end
            end
            S_HOLD: begin
               if (cnt <= 8'h01) begin
                  if (!phase_dac && !single_mode) begin
                     phase_dac <= 1'b1;
                     input_latch_enable_n <= 1'b1;
                     dac_latch_enable_n <= 1'b0;
                     cnt <= SETUP_CYC;
                     state <= S_SETUP;
                  end else begin
                     input_latch_enable_n <= 1'b1;
                     dac_latch_enable_n <= 1'b1;
                     state <= S_GAP;
                  end
               end else begin
                  cnt <= cnt - 8'h01;
               end
            end
            S_ZERO: begin
               if (cnt <= 8'h01) begin
                  zero_output_n <= 1'b1;
                  state <= S_GAP;
               end else begin
                  cnt <= cnt - 8'h01;
               end
               // Both latches go to the midpoint code while clear is low.
               in_latch <= `DLWP_BIPOLAR_MIDPOINT;
               dac_code <= `DLWP_BIPOLAR_MIDPOINT;
            end
            S_GAP: begin
               state <= S_IDLE;
            end
            default: begin
               state <= S_IDLE;
            end
         endcase
      end
   end
endmodule // dlwp_host
`default_nettype wire

// *** pkg/dlwp_defs.vh ***
/*
 Timing constants and codes for the parallel write port controller.
 Assumes a 100 MHz system clock; included by the controller file.
*/
`ifndef DLWP_DEFS_VH
`define DLWP_DEFS_VH
// ----------------------------------------
// Clock and timing
// ----------------------------------------
`define DLWP_CLK_PERIOD_NS 10
`define DLWP_WRITE_LOW_NS 50
`define DLWP_SINGLE_LOW_NS 80
`define DLWP_ZEROING_LOW_NS 200
`define DLWP_SETUP_NS 50
`define DLWP_HOLD_NS 10
`define DLWP_CYC(ns) (((ns) + `DLWP_CLK_PERIOD_NS - 1) / `DLWP_CLK_PERIOD_NS)
// ----------------------------------------
// Codes
// ----------------------------------------
`define DLWP_BIPOLAR_MIDPOINT 16'h0000
`define DLWP_MINUS_FULL 16'h8000
`define DLWP_PLUS_FULL 16'h7FFF
`endif

// *** rtl/dlwp_fifo.v ***
/*
 Synchronous FIFO with parameter width and depth, valid/ready on both sides.
 Assumes a single clock and a synchronous active-low reset.
*/
`default_nettype none
module dlwp_fifo #(
   parameter WIDTH = 16,
   parameter DEPTH = 16,
   parameter AW = 4
) (
   // Clock, reset and enable.
   input wire clk,
   input wire rst_n,
   input wire ce,
   // Fill side.
   input wire in_valid,
   output wire in_ready,
   input wire [WIDTH-1:0] in_data,
   // Drain side.
   output wire out_valid,
   input wire out_ready,
   output wire [WIDTH-1:0] out_data
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW-1:0] wr_ptr;
   reg [AW-1:0] rd_ptr;
   reg [AW:0] count;
   wire push;
   wire pop;

   // Full and empty come straight from the occupancy count.
   assign in_ready = (count != DEPTH[AW:0]);
   assign out_valid = (count != {(AW+1){1'b0}});
   assign out_data = mem[rd_ptr];
   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;

   // Pointer and count update; storage has no reset as it needs none.
   always @(posedge clk) begin
      if (!rst_n) begin
         wr_ptr <= {AW{1'b0}};
         rd_ptr <= {AW{1'b0}};
         count <= {(AW+1){1'b0}};
      end else if (ce) begin
         if (push) begin
            mem[wr_ptr] <= in_data;
            wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
         end
         if (push && !pop) begin
            count <= count + 1'b1;
         end else if (pop && !push) begin
            count <= count - 1'b1;
         end
      end
   end
endmodule // dlwp_fifo
`default_nettype wire

// *** tb/dlwp_dev_model.sv ***
/*
 Behavioural model of the converter's two level-sensitive latches.
 Assumes the pins come straight from the host controller.
*/
`default_nettype none
module dlwp_dev_model (
   // Converter pins.
   input wire logic [15:0] dac_data,
   input wire logic input_latch_enable_n,
   input wire logic dac_latch_enable_n,
   input wire logic write_n,
   input wire logic zero_output_n,
   // Latch contents.
   output logic [15:0] in_latch,
   output logic [15:0] out_code
);
   timeunit 1ns;
   timeprecision 1ps;
   // Clear beats everything; otherwise a low strobe opens each enabled latch.
   always @* begin
      if (!zero_output_n) begin
         in_latch = 16'h0000;
         out_code = 16'h0000;
      end else if (!write_n) begin
         if (!input_latch_enable_n) in_latch = dac_data;
         if (!dac_latch_enable_n) out_code = in_latch;
      end
   end
endmodule // dlwp_dev_model
`default_nettype wire

// *** tb/dlwp_host_chk.sv ***
/*
 Checker of the converter pin sequence driven by the write port controller.
 Assumes it is bound to the controller and sees only its ports.
*/
`default_nettype none
module dlwp_host_chk #(parameter WIDTH = 16) (
   // Clock and reset.
   input wire logic clk,
   input wire logic rst_n,
   // Converter pins and tracked code.
   input wire logic [WIDTH-1:0] dac_data,
   input wire logic input_latch_enable_n,
   input wire logic dac_latch_enable_n,
   input wire logic write_n,
   input wire logic zero_output_n,
   input wire logic [WIDTH-1:0] dac_code
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] low_count;
   wire split = input_latch_enable_n ^ dac_latch_enable_n;
   wire both_low = !input_latch_enable_n && !dac_latch_enable_n;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   // Counts clear-low cycles; it saturates so a stuck clear cannot wrap.
   always @(posedge clk) begin
      if (!rst_n || zero_output_n) low_count <= 8'h00;
      else if (low_count != 8'hFF) low_count <= low_count + 8'h01;
   end
   a_dbl_strobe_low: assert property ($fell(write_n) && split |-> !write_n [*5])
      else $error("strobe low too short");
   a_sgl_strobe_low: assert property ($fell(write_n) && both_low |-> !write_n [*8])
      else $error("single strobe too short");
   a_zero_low_min: assert property ($rose(zero_output_n) |-> low_count >= 8'h14)
      else $error("clear low too short");
   a_zero_forces_code: assert property (!zero_output_n ##1 !zero_output_n |-> dac_code == '0)
      else $error("code not zero under clear");
   a_strobe_needs_enable: assert property (!write_n |-> (split || both_low) && zero_output_n)
      else $error("strobe without enable");
   a_load_sets_code: assert property ($rose(write_n) && !dac_latch_enable_n |-> dac_code == dac_data)
      else $error("code not loaded");
   a_pins_hold_rise: assert property ($rose(write_n) |-> $stable({dac_data, split, both_low}))
      else $error("pins moved at strobe end");
   a_pins_setup_fall: assert property ($fell(write_n) |-> $stable({dac_data, split, both_low}))
      else $error("pins moved at strobe start");
   a_code_has_cause: assert property ($changed(dac_code) |-> $rose(write_n) || !zero_output_n)
      else $error("code changed without cause");
   c_zero: cover property ($rose(zero_output_n));
   c_double: cover property ($fell(write_n) && split);
   c_single: cover property ($fell(write_n) && both_low);
endmodule // dlwp_host_chk
bind dlwp_host dlwp_host_chk #(.WIDTH(WIDTH)) dlwp_host_chk_inst (
   .clk(clk),
   .rst_n(rst_n),
   .dac_data(dac_data),
   .input_latch_enable_n(input_latch_enable_n),
   .dac_latch_enable_n(dac_latch_enable_n),
   .write_n(write_n),
   .zero_output_n(zero_output_n),
   .dac_code(dac_code)
);
`default_nettype wire

// *** tb/tb.sv ***
/*
 Self-checking bench of the write port controller against a latch model.
 Assumes the controller, its FIFO and the latch model are compiled first.
*/
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0, rst_n = 1'b0, ce = 1'b1, sample_valid = 1'b0;
   logic single_buffer = 1'b0, zero_req = 1'b0, prev_wr = 1'b1;
   logic [15:0] sample_data = 16'h0000, last = 16'h0000;
   logic sample_ready, busy, input_latch_enable_n, dac_latch_enable_n, write_n, zero_output_n;
   logic [15:0] dac_data, dac_code, in_latch, out_code;
   logic [15:0] exp_q[$];
   logic [15:0] codes[4] = '{16'h8000, 16'h0000, 16'h7FFF, 16'hFFFF};
   int mismatches = 0, checks_done = 0, refused = 0;
   dlwp_host dlwp_host_inst (
      .clk(clk), .rst_n(rst_n), .ce(ce),
      .sample_valid(sample_valid), .sample_ready(sample_ready), .sample_data(sample_data),
      .single_buffer(single_buffer), .zero_req(zero_req), .busy(busy),
      .dac_data(dac_data), .input_latch_enable_n(input_latch_enable_n),
      .dac_latch_enable_n(dac_latch_enable_n), .write_n(write_n),
      .zero_output_n(zero_output_n), .dac_code(dac_code)
   );
   dlwp_dev_model dlwp_dev_model_inst (
      .dac_data(dac_data), .input_latch_enable_n(input_latch_enable_n),
      .dac_latch_enable_n(dac_latch_enable_n), .write_n(write_n),
      .zero_output_n(zero_output_n), .in_latch(in_latch), .out_code(out_code)
   );
   // Free-running 100 MHz clock.
   always #5 clk = ~clk;
   task automatic check(input string what, input logic [15:0] seen, exp);
      checks_done++;
      if (seen !== exp) begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   // Reference queue of accepted samples, popped at each converter latch load.
   always @(posedge clk) begin
      if (sample_valid && !sample_ready) refused++;
      // A sample is only taken on an edge with the clock enable high.
      if (sample_valid && sample_ready && ce) exp_q.push_back(sample_data);
      // Clear low on the pin means the converter latch now holds the midpoint.
      if (!zero_output_n) last = 16'h0000;
      if (write_n && !prev_wr && !input_latch_enable_n && dac_latch_enable_n) begin
         check("input latch", in_latch, exp_q[0]);
         check("held code", out_code, last);
      end
      if (write_n && !prev_wr && !dac_latch_enable_n) begin
         last = exp_q.pop_front();
         check("device code", out_code, last);
         check("tracked code", dac_code, last);
      end
      prev_wr <= write_n;
   end
   // Offers one sample and returns at the first edge after which sample_ready is high, or after 40 more edges.
   task automatic send(input logic [15:0] v);
      sample_valid <= 1'b1;
      sample_data <= v;
      @(posedge clk);
      for (int i = 0; i < 40 && !sample_ready; i++) @(posedge clk);
   endtask
   task automatic drain();
      sample_valid <= 1'b0;
      for (int i = 0; i < 900 && (busy || exp_q.size() > 0); i++) @(posedge clk);
   endtask
   // Only issued when idle, since a request while busy is ignored.
   task automatic zero();
      zero_req <= 1'b1;
      @(posedge clk);
      zero_req <= 1'b0;
      repeat (25) @(posedge clk);
      check("cleared input", in_latch, 16'h0000);
      check("cleared code", out_code, 16'h0000);
      check("tracked zero", dac_code, 16'h0000);
      check("idle after clear", 16'(busy), 16'h0000);
   endtask
   initial begin
      void'($urandom(32'h848E));
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      zero();
      for (int m = 0; m < 2; m++) begin
         single_buffer <= m[0];
         foreach (codes[i]) send(codes[i]);
         // Freeze the controller mid-write; pins and latches must simply pause.
         sample_valid <= 1'b0;
         ce <= 1'b0;
         repeat (3) @(posedge clk);
         ce <= 1'b1;
         repeat (20) send(16'($urandom()));
         drain();
         zero();
      end
      check("pending", 16'(exp_q.size()), 16'h0000);
      check("refused", 16'(refused > 0), 16'h0001);
      print_verdict();
   end
   // A hang counts as a mismatch.
   initial begin
      #50000;
      mismatches++;
      print_verdict();
   end
endmodule // tb
`default_nettype wire
